//--- pkg/stm_params.svh
// constants for the standard timer: register offsets, field positions,
// reset values and code points.
// assumes inclusion by bare name from the timer package and design files.
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH

// ****************************************************************
// register byte offsets on the avalon slave
// ****************************************************************
`define STM_OFS_CTRL 8'h00
`define STM_OFS_CNT_LO 8'h04
`define STM_OFS_CNT_HI 8'h08
`define STM_OFS_COMPARE_REGISTER_A_LO 8'h0c
`define STM_OFS_COMPARE_REGISTER_A_HI 8'h10
`define STM_OFS_COMPARE_REGISTER_P 8'h14
`define STM_OFS_STAT 8'h18

// ****************************************************************
// widths, field positions and reset values
// ****************************************************************
`define STM_CNT_W 10
`define STM_COMPARE_REGISTER_P_W 3
`define STM_CTRL_W 10
`define STM_FLD_RUN 0
`define STM_STAT_A 0
`define STM_STAT_P 1
`define STM_CTRL_RST 10'h000
`define STM_CNT_RST 10'h000
`define STM_COMPARE_REGISTER_A_RST 10'h000
`define STM_COMPARE_REGISTER_P_RST 3'h0
`define STM_STAT_RST 2'h0

// ****************************************************************
// pin-function codes
// ****************************************************************
`define STM_FN_RISE 2'h0
`define STM_FN_FALL 2'h1
`define STM_FN_BOTH 2'h2
`define STM_FN_NONE 2'h3
`define STM_FN_PULSE 2'h3

`endif

//--- pkg/stm_pkg.sv
// types shared by the standard timer design files.
// assumes stm_params.svh on the include path.
`include "stm_params.svh"

package stm_pkg;

  // ****************************************************************
  // operating modes, in mode-select code order 00, 01, 10, 11
  // ****************************************************************
  typedef enum logic [1:0] {
    STM_MODE_COMPARE,
    STM_MODE_CAPTURE,
    STM_MODE_PULSE,
    STM_MODE_TIMER
  } stm_mode_e;

  // ****************************************************************
  // control register layout, run bit at bit 0
  // ****************************************************************
  typedef struct packed {
    logic cap_pin_sel;
    logic duty_period_swap;
    logic counter_clear_select;
    logic output_polarity;
    logic output_initial_level;
    logic mode_select_hi;
    logic mode_select_lo;
    logic pin_function_hi;
    logic pin_function_lo;
    logic timer_run_bit;
  } stm_ctrl_s;

endpackage : stm_pkg

//--- hw/stm_pin_edge.sv
// two-flop synchroniser and edge finder for asynchronous pins.
// assumes pins are asynchronous to clk_i; edges appear 2 edges after the pin.
`timescale 1ns/1ps

module stm_pin_edge #(
  parameter int N = 3
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [N-1:0] pin_i,
  output logic [N-1:0] rise_o,
  output logic [N-1:0] fall_o
);

  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] prev_q;

  // first stage only feeds the second
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edges compare only settled stages
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;

endmodule : stm_pin_edge

//--- hw/stm_match.sv
// comparators a and p of the standard timer.
// assumes counter and compare values from the same clock domain.
`timescale 1ns/1ps

module stm_match #(
  parameter int CW = 10,
  parameter int PW = 3
) (
  input wire logic [CW-1:0] cnt_i,
  input wire logic [CW-1:0] compare_register_a_i,
  input wire logic [PW-1:0] compare_register_p_i,
  output logic match_a_o,
  output logic match_p_o
);

  // full ten-bit equality for comparator a
  assign match_a_o = (cnt_i == compare_register_a_i);

  // upper bits against p; zero means the counter's top value
  always_comb begin
    if (compare_register_p_i == '0) begin
      match_p_o = (cnt_i == {CW{1'b1}}); // RULE18
    end else begin
      match_p_o = (cnt_i[CW-1 -: PW] == compare_register_p_i) && (cnt_i[CW-PW-1:0] == '0); // RULE24
    end
  end

endmodule : stm_match

//--- hw/stm_timer.sv
// standard timer: single pulse and capture input modes, avalon-mm slave.
// assumes one clock, synchronous active-low reset, asynchronous pins.
//
// Notes on behaviour
// [RULE1] software selects single pulse with mode 10 and pin function 11
// [RULE2] run bit rising starts the pulse leading edge
// [RULE3] trigger pin edge sets run bit in single pulse mode
// [RULE4] run high starts counter and drives active pulse level
// [RULE5] pulse ends when run clears by software or comparator a
// [RULE6] comparator a match clears run, so compare_register_a sets pulse width
// [RULE7] comparator a match raises the a interrupt request
// [RULE8] single pulse counter zeroes only when run rises
// [RULE9] single pulse ignores compare_register_p, clear-select and swap bits
// [RULE10] software keeps pin function at 11 during single pulse
// [RULE11] software selects capture with mode 01
// [RULE12] capture source is one of two pins, edge chosen by pin function
// [RULE13] pin function 00 rising, 01 falling, 10 both
// [RULE14] capture counter starts when run rises
// [RULE15] active capture edge copies counter to compare_register_a and raises interrupt
// [RULE16] capture counter free-runs until run falls
// [RULE17] comparator p match zeroes counter and raises interrupt
// [RULE18] compare_register_p zero gives the full counter range
// [RULE19] pin function 11 disables capture but counter runs
// [RULE20] capture pin edges count even when pin drives as output
// [RULE21] capture ignores level, polarity, clear-select, swap; no output
// [RULE22] ten-bit counter, upper two bits readable apart
// [RULE23] compare_register_a is ten bits, low byte and two-bit high part
// [RULE24] comparator p matches upper three bits; zero means 1024 counts
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "stm_params.svh"

module stm_timer #(
  parameter int CW = `STM_CNT_W,
  parameter int PW = `STM_COMPARE_REGISTER_P_W
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_trigger_pin_i,
  input wire logic capture_pin_zero_i,
  input wire logic capture_pin_one_i,
  output logic pulse_o,
  output logic pulse_oe_o,
  output logic irq_a_o,
  output logic irq_p_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  stm_pkg::stm_ctrl_s ctrl_q;
  stm_pkg::stm_mode_e mode;
  logic run_q;
  logic run_d;
  logic run_prev_q;
  logic run_rise;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] compare_register_a_q;
  logic [PW-1:0] compare_register_p_q;
  logic [1:0] stat_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_go;
  logic [2:0] rise;
  logic [2:0] fall;
  logic match_a;
  logic match_p;
  logic [1:0] pin_fn;
  logic sp_mode;
  logic cap_mode;
  logic sp_hit_a;
  logic cap_edge;
  logic cap_event;
  logic ovf_event;
  logic pulse_q;
  logic pulse_oe_q;
  logic irq_a_q;
  logic irq_p_q;
  stm_pkg::stm_ctrl_s ctrl_d;
  logic sp_mode_d;

  // ****************************************************************
  // pins and comparators
  // ****************************************************************
  // pin 0 trigger, pin 1 capture zero, pin 2 capture one
  stm_pin_edge #(
    .N(3)
  ) u_pins (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i({capture_pin_one_i, capture_pin_zero_i, external_trigger_pin_i}),
    .rise_o(rise),
    .fall_o(fall)
  );

  stm_match #(
    .CW(CW),
    .PW(PW)
  ) u_match (
    .cnt_i(cnt_q),
    .compare_register_a_i(compare_register_a_q),
    .compare_register_p_i(compare_register_p_q),
    .match_a_o(match_a),
    .match_p_o(match_p)
  );

  // ****************************************************************
  // mode decode and events
  // ****************************************************************
  // software keeps mode and pin function legal; unused modes stay idle
  assign mode = stm_pkg::stm_mode_e'({ctrl_q.mode_select_hi, ctrl_q.mode_select_lo}); // RULE1 RULE11
  assign pin_fn = {ctrl_q.pin_function_hi, ctrl_q.pin_function_lo};
  assign sp_mode = (mode == stm_pkg::STM_MODE_PULSE) && (pin_fn == `STM_FN_PULSE); // RULE1 RULE10
  assign cap_mode = (mode == stm_pkg::STM_MODE_CAPTURE);
  assign run_rise = run_q && !run_prev_q;

  // compare a is skipped on the restart cycle, when cnt_q is still stale
  assign sp_hit_a = sp_mode && run_q && run_prev_q && match_a; // RULE6

  // pin selected by cap_pin_sel; direction of the pin is not looked at
  always_comb begin
    cap_edge = 1'b0;
    unique case (pin_fn) // RULE13
      `STM_FN_RISE: cap_edge = ctrl_q.cap_pin_sel ? rise[2] : rise[1]; // RULE12 RULE20
      `STM_FN_FALL: cap_edge = ctrl_q.cap_pin_sel ? fall[2] : fall[1]; // RULE12
      `STM_FN_BOTH: cap_edge = ctrl_q.cap_pin_sel ? (rise[2] | fall[2]) : (rise[1] | fall[1]);
      `STM_FN_NONE: cap_edge = 1'b0; // RULE19
    endcase
  end

  assign cap_event = cap_mode && run_q && cap_edge;
  // clear-select and swap bits are never read by either mode
  assign ovf_event = cap_mode && run_q && run_prev_q && match_p; // RULE17 RULE9 RULE21

  // ****************************************************************
  // avalon slave handshake
  // ****************************************************************
  // one wait cycle per access; data is registered on the first cycle
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_go = avs_write && ack_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (avs_address)
      `STM_OFS_CTRL: rdata_d[`STM_CTRL_W-1:0] = {ctrl_q[`STM_CTRL_W-1:1], run_q};
      `STM_OFS_CNT_LO: rdata_d[7:0] = cnt_q[7:0];
      `STM_OFS_CNT_HI: rdata_d[CW-9:0] = cnt_q[CW-1:8]; // RULE22
      `STM_OFS_COMPARE_REGISTER_A_LO: rdata_d[7:0] = compare_register_a_q[7:0];
      `STM_OFS_COMPARE_REGISTER_A_HI: rdata_d[CW-9:0] = compare_register_a_q[CW-1:8]; // RULE23
      `STM_OFS_COMPARE_REGISTER_P: rdata_d[PW-1:0] = compare_register_p_q;
      `STM_OFS_STAT: rdata_d[1:0] = stat_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // control register (run bit held apart)
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `STM_CTRL_RST;
    end else if (wr_go && avs_address == `STM_OFS_CTRL) begin
      if (avs_byteenable[0]) begin
        ctrl_q[7:1] <= avs_writedata[7:1];
      end
      if (avs_byteenable[1]) begin
        ctrl_q[`STM_CTRL_W-1:8] <= avs_writedata[`STM_CTRL_W-1:8];
      end
    end
  end

  // later lines win: software, then compare-a clear, then pin trigger
  always_comb begin
    run_d = run_q;
    if (wr_go && avs_address == `STM_OFS_CTRL && avs_byteenable[0]) begin
      run_d = avs_writedata[`STM_FLD_RUN]; // RULE5
    end
    if (sp_hit_a) begin
      run_d = 1'b0; // RULE6 RULE5
    end
    if (sp_mode && rise[0]) begin
      run_d = 1'b1; // RULE3
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      run_q <= 1'b0;
      run_prev_q <= 1'b0;
    end else begin
      run_q <= run_d;
      run_prev_q <= run_q;
    end
  end

  // ****************************************************************
  // counter
  // ****************************************************************
  // stops holding its value when run falls; zeroes on restart and on a capture-mode p match
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_q <= `STM_CNT_RST;
    end else if (run_rise) begin
      cnt_q <= '0; // RULE8 RULE14 RULE4
    end else if (run_q && ovf_event) begin
      cnt_q <= '0; // RULE17
    end else if (run_q && (sp_mode || cap_mode)) begin
      cnt_q <= cnt_q + CW'(1); // RULE16 RULE4
    end
  end

  // ****************************************************************
  // compare registers
  // ****************************************************************
  // a capture wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      compare_register_a_q <= `STM_COMPARE_REGISTER_A_RST;
    end else if (cap_event) begin
      compare_register_a_q <= cnt_q; // RULE15
    end else if (wr_go && avs_byteenable[0]) begin
      if (avs_address == `STM_OFS_COMPARE_REGISTER_A_LO) begin
        compare_register_a_q[7:0] <= avs_writedata[7:0];
      end
      if (avs_address == `STM_OFS_COMPARE_REGISTER_A_HI) begin
        compare_register_a_q[CW-1:8] <= avs_writedata[CW-9:0]; // RULE23
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      compare_register_p_q <= `STM_COMPARE_REGISTER_P_RST;
    end else if (wr_go && avs_byteenable[0] && avs_address == `STM_OFS_COMPARE_REGISTER_P) begin
      compare_register_p_q <= avs_writedata[PW-1:0];
    end
  end

  // ****************************************************************
  // event flags and request pulses
  // ****************************************************************
  // sticky, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stat_q <= `STM_STAT_RST;
    end else begin
      if (wr_go && avs_byteenable[0] && avs_address == `STM_OFS_STAT) begin
        stat_q <= stat_q & ~avs_writedata[1:0];
      end
      if (sp_hit_a || cap_event) begin
        stat_q[`STM_STAT_A] <= 1'b1; // RULE7 RULE15
      end
      if (ovf_event) begin
        stat_q[`STM_STAT_P] <= 1'b1; // RULE17
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_a_q <= 1'b0;
      irq_p_q <= 1'b0;
    end else begin
      irq_a_q <= sp_hit_a || cap_event; // RULE7 RULE15
      irq_p_q <= ovf_event; // RULE17
    end
  end

  assign irq_a_o = irq_a_q;
  assign irq_p_o = irq_p_q;

  // ****************************************************************
  // pulse output
  // ****************************************************************
  // next lane-0 control value, so one write that picks single pulse and sets run starts the pin at once
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_go && avs_address == `STM_OFS_CTRL && avs_byteenable[0]) begin
      ctrl_d[7:1] = avs_writedata[7:1];
    end
  end
  assign sp_mode_d = (stm_pkg::stm_mode_e'({ctrl_d.mode_select_hi, ctrl_d.mode_select_lo}) == stm_pkg::STM_MODE_PULSE)
    && ({ctrl_d.pin_function_hi, ctrl_d.pin_function_lo} == `STM_FN_PULSE); // RULE1

  // follows run_d so the pin edge lines up with run_q
  // capture and idle modes release the pin
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pulse_q <= 1'b0;
      pulse_oe_q <= 1'b0;
    end else begin
      pulse_q <= sp_mode_d && (run_d ^ ctrl_d.output_polarity); // RULE2 RULE4 RULE5
      pulse_oe_q <= sp_mode_d; // RULE21
    end
  end

  assign pulse_o = pulse_q;
  assign pulse_oe_o = pulse_oe_q;

endmodule : stm_timer

//--- bench/stm_pins.sv
// far-side pin model: trigger and both capture pins.
// assumes the bench calls set_pin hierarchically; pins idle low.
`timescale 1ns/1ps

module stm_pins (
  input wire logic clk_i,
  output logic trig_o,
  output logic cap0_o,
  output logic cap1_o
);
  // ************************************************************
  // pin drive
  // ************************************************************
  // idle levels at time zero
  initial begin
    trig_o = 1'b0;
    cap0_o = 1'b0;
    cap1_o = 1'b0;
  end
  // pins move just after an edge; the design treats them as async anyway
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk_i);
    case (idx)
      0: trig_o <= v;
      1: cap0_o <= v;
      default: cap1_o <= v;
    endcase
  endtask : set_pin
endmodule : stm_pins

//--- bench/stm_timer_chk.sv
// port checker for the standard timer.
// assumes polarity bit left at 0 by every single pulse scenario.
`timescale 1ns/1ps

module stm_timer_chk #(
  parameter int CW = 10,
  parameter int PW = 3
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic external_trigger_pin_i,
  input wire logic capture_pin_zero_i,
  input wire logic capture_pin_one_i,
  input wire logic pulse_o,
  input wire logic pulse_oe_o,
  input wire logic irq_a_o,
  input wire logic irq_p_o
);
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // bus: one wait state, never more
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait state");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state too long");
  a_irq_a_pulse: assert property (irq_a_o |=> !irq_a_o) else $error("irq a not one cycle");
  a_irq_p_pulse: assert property (irq_p_o |=> !irq_p_o) else $error("irq p not one cycle");
  a_no_out_noe: assert property (!pulse_oe_o |-> !pulse_o) else $error("output without enable");
  a_irq_p_mode: assert property (irq_p_o |-> !pulse_oe_o) else $error("p match in pulse mode");
  // match interrupt and trailing edge land together
  a_match_ends: assert property (irq_a_o && pulse_oe_o && $past(pulse_oe_o) |-> pulse_o != $past(pulse_o))
    else $error("a match without trailing edge");
  // trigger edge passes two sync flops and the pulse output flop
  a_trig_starts: assert property ($rose(external_trigger_pin_i) && pulse_oe_o && !pulse_o |-> ##4 pulse_o)
    else $error("trigger did not start pulse");
  a_pulse_min: assert property ($rose(pulse_o) && pulse_oe_o |=> pulse_o) else $error("pulse too short");
  // a capture interrupt needs a pin change three edges back
  a_cap_edge: assert property (irq_a_o && !pulse_oe_o |-> ($past(capture_pin_zero_i, 3) !=
    $past(capture_pin_zero_i, 4)) || ($past(capture_pin_one_i, 3) != $past(capture_pin_one_i, 4)))
    else $error("capture irq without pin edge");
endmodule : stm_timer_chk

bind stm_timer stm_timer_chk #(.CW(CW), .PW(PW)) u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .external_trigger_pin_i(external_trigger_pin_i), .capture_pin_zero_i(capture_pin_zero_i),
  .capture_pin_one_i(capture_pin_one_i), .pulse_o(pulse_o), .pulse_oe_o(pulse_oe_o),
  .irq_a_o(irq_a_o), .irq_p_o(irq_p_o));

//--- bench/testbench.sv
// self-checking bench for the standard timer over avalon-mm.
// assumes stm_pins as pin source and the bound port checker.
`timescale 1ns/1ps

module testbench;
  logic clk_i, reset_n_i, avs_read, avs_write, avs_waitrequest;
  logic pulse_o, pulse_oe_o, irq_a_o, irq_p_o, trig, cap0, cap1;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, v1, ctl;
  int errors, checks_done, na, np, n0, w;

  // ************************************************************
  // clock, instances, event counters
  // ************************************************************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  stm_pins pins (.clk_i(clk_i), .trig_o(trig), .cap0_o(cap0), .cap1_o(cap1));
  stm_timer dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .external_trigger_pin_i(trig),
    .capture_pin_zero_i(cap0), .capture_pin_one_i(cap1), .pulse_o(pulse_o), .pulse_oe_o(pulse_oe_o),
    .irq_a_o(irq_a_o), .irq_p_o(irq_p_o));
  // irq pulses are one cycle, so count them at every edge
  always @(posedge clk_i) begin
    if (irq_a_o === 1'b1) na++;
    if (irq_p_o === 1'b1) np++;
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one access; an edge passes first so strobes never toggle twice in a step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk("bus answer", 32'h1, 32'h0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdc
  // pulse length in cycles, from first high sample to first low one
  task automatic width();
    int n;
    n = 0;
    w = 0;
    while (pulse_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    while (pulse_o === 1'b1 && w < 2000) begin
      @(posedge clk_i);
      w++;
    end
  endtask : width
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // ************************************************************
  // watchdog and main sequence
  // ************************************************************
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    close_out();
  end
  initial begin
    {reset_n_i, avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
    {errors, checks_done, na, np} = '0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdc("ctrl reset", 8'h00, 32'h0);
    rdc("compare_register_a reset", 8'h0c, 32'h0);
    rdc("compare_register_p reset", 8'h14, 32'h0);
    bus(1'b1, 8'h04, 32'h55);
    rdc("cnt lo read only", 8'h04, 32'h0);
    bus(1'b1, 8'h1c, 32'hff);
    rdc("unmapped", 8'h1c, 32'h0);
    // software pulse, second pass with high compare_register_a part and ignored fields set
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 8'h0c, i ? 32'h0 : 32'h5);
      bus(1'b1, 8'h10, i);
      bus(1'b1, 8'h14, i);
      n0 = na;
      bus(1'b1, 8'h00, i ? 32'h197 : 32'h17);
      width();
      @(posedge clk_i); // irq counter sees the match pulse first
      chk("pulse width", i ? 32'd258 : 32'd7, w);
      chk("match irq", 32'd1, na - n0);
      rdc("run cleared", 8'h00, i ? 32'h196 : 32'h16);
      rdc("flag a", 8'h18, 32'h1);
      bus(1'b1, 8'h18, 32'h3);
    end
    // pin trigger
    bus(1'b1, 8'h0c, 32'h3);
    bus(1'b1, 8'h10, 32'h0);
    bus(1'b1, 8'h00, 32'h16);
    pins.set_pin(0, 1'b1);
    width();
    chk("trigger width", 32'd5, w);
    pins.set_pin(0, 1'b0);
    bus(1'b1, 8'h18, 32'h3);
    // software ends a long pulse
    bus(1'b1, 8'h0c, 32'hff);
    bus(1'b1, 8'h10, 32'h3);
    bus(1'b1, 8'h00, 32'h17);
    repeat (5) @(posedge clk_i);
    bus(1'b1, 8'h00, 32'h16);
    @(posedge clk_i);
    chk("pulse after clear", 32'h0, pulse_o);
    rdc("no match flag", 8'h18, 32'h0);
    // capture: every pin function on both pins, other pin wiggled too
    bus(1'b1, 8'h14, 32'h0);
    for (int k = 0; k < 8; k++) begin
      ctl = 32'h1e9 | (k[1:0] << 1) | (k[2] << 9);
      bus(1'b1, 8'h00, ctl);
      n0 = na;
      for (int p = 0; p < 4; p++) begin
        pins.set_pin(p[1] ? 2 - k[2] : 1 + k[2], ~p[0]);
        repeat (8) @(posedge clk_i);
      end
      chk("capture count", (k[1:0] == 2) ? 2 : (k[1:0] == 3 ? 0 : 1), na - n0);
      rdc("capture value", 8'h0c, k[1:0] ? 32'd11 : 32'd2);
      chk("no output", 32'h0, {pulse_oe_o, pulse_o});
      bus(1'b0, 8'h04, 32'h0);
      v1 = rd;
      rdc("counter runs", 8'h04, v1 + 32'd3);
      bus(1'b1, 8'h00, ctl ^ 32'h1);
      bus(1'b0, 8'h04, 32'h0);
      v1 = rd;
      rdc("counter stopped", 8'h04, v1);
    end
    // period match at 128, then full range with zero
    bus(1'b1, 8'h18, 32'h3);
    bus(1'b1, 8'h14, 32'h1);
    n0 = np;
    bus(1'b1, 8'h00, 32'h0f);
    repeat (300) @(posedge clk_i);
    chk("p matches", 32'd2, np - n0);
    rdc("flag p", 8'h18, 32'h2);
    rdc("cnt hi short", 8'h08, 32'h0);
    bus(1'b1, 8'h00, 32'h0e);
    bus(1'b1, 8'h14, 32'h0);
    n0 = np;
    bus(1'b1, 8'h00, 32'h0f);
    repeat (1000) @(posedge clk_i);
    rdc("cnt hi full", 8'h08, 32'h3);
    repeat (100) @(posedge clk_i);
    chk("full range match", 32'd1, np - n0);
    close_out();
  end
endmodule : testbench
